// ==== logic/pa_boost_pkg.sv ====
package pa_boost_pkg;
    // link register port geometry
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;

    // device register offsets and reset values
    localparam logic [8:0] STATE_VOLTAGE_OFS = 9'h03B;
    localparam logic [8:0] DISCHARGE_OFS = 9'h1C7;
    localparam logic [7:0] STATE_VOLTAGE_RST = 8'h24;
    localparam logic [7:0] DISCHARGE_RST = 8'h01;

    // field positions of the state and voltage register and the discharge register
    localparam int STATE_LSB = 0;
    localparam int STBY_LSB = 3;
    localparam int SEL_LSB = 6;
    localparam int STBY_COPY_BIT = 5;   // codes 4..7 are copied
    localparam int DIS_BIT = 0;

    // state and voltage codes
    localparam logic [2:0] STATE_OFF = 3'h4;
    localparam logic [2:0] STATE_ON = 3'h7;
    localparam logic [1:0] SEL_4V2 = 2'h0;
    localparam logic [1:0] SEL_5V0 = 2'h2;

    // soft start blanking time
    localparam int CLK_MHZ = 100;
    localparam int SOFTSTART_US = 4000;
    localparam int SOFTSTART_CYC_DEF = SOFTSTART_US * CLK_MHZ;
    localparam int SS_W = 20;

    // analog comparator input index
    localparam int CMP_UV = 0;
    localparam int CMP_OC = 1;
    localparam int CMP_SC = 2;
    localparam int CMP_OV = 3;
    localparam int CMP_N = 4;

    // host controller wishbone map
    localparam logic [7:0] HC_CMD_OFS = 8'h00;
    localparam logic [7:0] HC_STAT_OFS = 8'h04;
    localparam logic [7:0] HC_IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] HC_IRQ_MASK_OFS = 8'h0C;
    localparam logic [7:0] HC_STBY_OFS = 8'h10;
    localparam int CMD_ADDR_LSB = 0;
    localparam int CMD_DATA_LSB = 16;
    localparam int CMD_WE_BIT = 24;
    localparam int CMD_GO_BIT = 31;
    localparam int STAT_RDATA_LSB = 8;
    localparam int IRQ_N = 3;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_FAULT_SET = 1;
    localparam int IRQ_FAULT_CLR = 2;
endpackage

// ==== logic/pa_link_if.sv ====
`timescale 1ns/1ps
interface pa_link_if;
    import pa_boost_pkg::*;
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic ack;
    logic pa_boost_fault_flag;
    logic standby_exit_pin;

    modport dev (
        input req, we, addr, wdata, standby_exit_pin,
        output rdata, ack, pa_boost_fault_flag
    );
    modport host (
        output req, we, addr, wdata, standby_exit_pin,
        input rdata, ack, pa_boost_fault_flag
    );
endinterface

// ==== logic/pa_boost_supervisor.sv ====
`timescale 1ns/1ps
module pa_boost_supervisor
    import pa_boost_pkg::*;
#(
    parameter int SOFTSTART_CYCLES = SOFTSTART_CYC_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    pa_link_if.dev link,
    input wire logic uv_low_i,
    input wire logic oc_i,
    input wire logic sc_i,
    input wire logic ov_i,
    output logic pa_boost_regulator_en_o,
    output logic uv_comp_en_o,
    output logic switch_block_o,
    output logic isolation_switch_en_o,
    output logic discharge_en_o,
    output logic vsel_5v0_o,
    output logic soft_start_o
);
    logic [CMP_N-1:0] cmp_raw;
    logic [CMP_N-1:0] s1_q;
    logic [CMP_N-1:0] s2_q;
    logic [CMP_N-1:0] s3_q;
    logic [CMP_N-1:0] flt_q;
    logic [DATA_W-1:0] ctrl_q;
    logic [DATA_W-1:0] ctrl_d;
    logic [DATA_W-1:0] dis_q;
    logic [DATA_W-1:0] rdata_q;
    logic ack_q;
    logic stby_q;
    logic sc_q;
    logic ov_q;
    logic fault_q;
    logic [SS_W-1:0] ss_cnt_q;
    // link decode: a held request is taken once, masked while ack stands
    wire access = link.req & ~ack_q;
    wire wr_ctrl = access & link.we & (link.addr == STATE_VOLTAGE_OFS);
    wire wr_dis = access & link.we & (link.addr == DISCHARGE_OFS);
    // standby exit acts on the rising edge, codes 0 to 3 never copied
    wire stby_rise = link.standby_exit_pin & ~stby_q;
    wire [2:0] stby_field = ctrl_q[STBY_LSB +: 3];
    wire stby_copy = stby_rise & stby_field[STBY_COPY_BIT - STBY_LSB];
    wire [2:0] state_d = ctrl_d[STATE_LSB +: 3];
    wire [2:0] state_q = ctrl_q[STATE_LSB +: 3];
    // a set latch keeps the regulator off until the next re-enable
    wire reenable = (wr_ctrl | stby_copy) & (state_d == STATE_ON);
    wire on_cmd = (state_q == STATE_ON);
    wire on_eff = on_cmd & ~sc_q & ~ov_q;
    wire ss_done = (ss_cnt_q == SS_W'(SOFTSTART_CYCLES));
    // fault causes, short only seen once soft start is over
    wire uv_flt = flt_q[CMP_UV];
    wire oc_flt = flt_q[CMP_OC];
    wire sc_set = on_eff & ss_done & flt_q[CMP_SC];
    wire ov_set = on_eff & flt_q[CMP_OV];
    wire [1:0] sel = ctrl_q[SEL_LSB +: 2];
    // readback of the two device registers, other addresses give zero
    wire [DATA_W-1:0] rd_mux =
        (link.addr == STATE_VOLTAGE_OFS) ? ctrl_q :
        (link.addr == DISCHARGE_OFS) ? dis_q : '0;
    wire fault_d = (on_eff & (uv_flt | oc_flt)) | sc_q | ov_q;

    assign cmp_raw = {ov_i, sc_i, oc_i, uv_low_i};

    // comparator pins pass three flops, change taken when two agree
    genvar gi;
    generate
        for (gi = 0; gi < CMP_N; gi++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                    flt_q[gi] <= 1'b0;
                end else if (ce_i) begin
                    s1_q[gi] <= cmp_raw[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        flt_q[gi] <= s3_q[gi];
                    end
                end
            end
        end
    endgenerate

    // next control value: host write first, then standby copy
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = link.wdata;
        end else if (stby_copy) begin
            ctrl_d[STATE_LSB +: 3] = stby_field;
        end
    end

    // register port, answer one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= STATE_VOLTAGE_RST;
            dis_q <= DISCHARGE_RST;
            ack_q <= 1'b0;
            rdata_q <= '0;
            stby_q <= 1'b0;
        end else if (ce_i) begin
            ctrl_q <= ctrl_d;
            stby_q <= link.standby_exit_pin;
            ack_q <= access;
            if (access & ~link.we) begin
                rdata_q <= rd_mux;
            end
            if (wr_dis) begin
                dis_q <= {7'h00, link.wdata[DIS_BIT]};
            end
        end
    end

    // fault latches: a new fault wins over the re-enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sc_q <= 1'b0;
            ov_q <= 1'b0;
        end else if (ce_i) begin
            if (sc_set) begin
                sc_q <= 1'b1;
            end else if (reenable) begin
                sc_q <= 1'b0;
            end
            if (ov_set) begin
                ov_q <= 1'b1;
            end else if (reenable) begin
                ov_q <= 1'b0;
            end
        end
    end

    // soft start timer restarts whenever the regulator is off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ss_cnt_q <= '0;
        end else if (ce_i) begin
            if (!on_eff || reenable) begin
                ss_cnt_q <= '0;
            end else if (!ss_done) begin
                ss_cnt_q <= ss_cnt_q + 1'b1;
            end
        end
    end

    // fault flag towards the host
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_q <= 1'b0;
        end else if (ce_i) begin
            fault_q <= fault_d;
        end
    end

    // link answers, all straight from flops
    assign link.ack = ack_q;
    assign link.rdata = rdata_q;
    assign link.pa_boost_fault_flag = fault_q;

    // analog control outputs
    assign pa_boost_regulator_en_o = on_eff;
    assign uv_comp_en_o = on_eff;
    assign switch_block_o = on_eff & oc_flt;
    assign isolation_switch_en_o = on_eff;
    // discharge only when enabled and off
    assign discharge_en_o = ~dis_q[DIS_BIT] & ~on_eff;
    assign vsel_5v0_o = (sel == SEL_5V0);
    assign soft_start_o = on_eff & ~ss_done;
endmodule

// ==== logic/pa_boost_host_ctrl.sv ====
`timescale 1ns/1ps
module pa_boost_host_ctrl
    import pa_boost_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    pa_link_if.host link
);
    logic ack_q;
    logic [31:0] dat_q;
    logic req_q;
    logic we_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] rdata_q;
    logic stby_q;
    logic fault_q;
    logic [IRQ_N-1:0] irq_stat_q;
    logic [IRQ_N-1:0] irq_mask_q;
    logic [IRQ_N-1:0] irq_ev;
    wire wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire wb_wr = wb_req & wb_we_i & (&wb_sel_i);
    wire wr_cmd = wb_wr & (wb_adr_i == HC_CMD_OFS);
    wire go = wr_cmd & wb_dat_i[CMD_GO_BIT] & ~req_q;
    wire wr_istat = wb_wr & (wb_adr_i == HC_IRQ_STAT_OFS);
    wire wr_imask = wb_wr & (wb_adr_i == HC_IRQ_MASK_OFS);
    wire wr_stby = wb_wr & (wb_adr_i == HC_STBY_OFS);
    wire done = req_q & link.ack;
    wire [31:0] stat_word = {16'h0000, rdata_q, 6'h00,
                             link.pa_boost_fault_flag, req_q};
    wire [31:0] rd_mux =
        (wb_adr_i == HC_STAT_OFS) ? stat_word :
        (wb_adr_i == HC_IRQ_STAT_OFS) ? {29'h0, irq_stat_q} :
        (wb_adr_i == HC_IRQ_MASK_OFS) ? {29'h0, irq_mask_q} :
        (wb_adr_i == HC_STBY_OFS) ? {31'h0, stby_q} : 32'h0000_0000;

    // events: transfer done, fault rising, fault falling
    assign irq_ev[IRQ_DONE] = done;
    assign irq_ev[IRQ_FAULT_SET] = link.pa_boost_fault_flag & ~fault_q;
    assign irq_ev[IRQ_FAULT_CLR] = ~link.pa_boost_fault_flag & fault_q;

    // wishbone slave, ack one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
            irq_mask_q <= '0;
            stby_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= wb_req;
            if (wb_req) begin
                dat_q <= wb_we_i ? 32'h0000_0000 : rd_mux;
            end
            if (wr_imask) begin
                irq_mask_q <= wb_dat_i[IRQ_N-1:0];
            end
            if (wr_stby) begin
                stby_q <= wb_dat_i[0];
            end
        end
    end

    // sticky status, a new event wins over the clearing write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= '0;
            fault_q <= 1'b0;
        end else if (ce_i) begin
            fault_q <= link.pa_boost_fault_flag;
            irq_stat_q <= irq_ev |
                (irq_stat_q & ~(wr_istat ? wb_dat_i[IRQ_N-1:0] : '0));
        end
    end

    // link request held until the device acknowledges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_q <= 1'b0;
            we_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
        end else if (ce_i) begin
            if (go) begin
                req_q <= 1'b1;
                we_q <= wb_dat_i[CMD_WE_BIT];
                addr_q <= wb_dat_i[CMD_ADDR_LSB +: ADDR_W];
                wdata_q <= wb_dat_i[CMD_DATA_LSB +: DATA_W];
            end else if (done) begin
                req_q <= 1'b0;
                if (!we_q) begin
                    rdata_q <= link.rdata;
                end
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign irq_o = |(irq_stat_q & irq_mask_q);
    assign link.req = req_q;
    assign link.we = we_q;
    assign link.addr = addr_q;
    assign link.wdata = wdata_q;
    assign link.standby_exit_pin = stby_q;
endmodule

// ==== sim/pa_link_properties.sv ====
`timescale 1ns/1ps
module pa_link_properties
    import pa_boost_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req,
    input wire logic we,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic ack,
    input wire logic pa_boost_fault_flag,
    input wire logic standby_exit_pin
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic dis_q;
    wire wr_dis = ack && we && addr == DISCHARGE_OFS;
    wire rd_map = addr == DISCHARGE_OFS || addr == STATE_VOLTAGE_OFS;
    // shadow of the discharge bit last written over the link
    always_ff @(posedge clk_i) begin
        if (rst_i)
            dis_q <= DISCHARGE_RST[0];
        else if (wr_dis)
            dis_q <= wdata[DIS_BIT];
    end
    ack_on_req_a: assert property ($rose(req) |=> ack)
        else $error("link ack missing");
    ack_one_cycle_a: assert property (ack |=> !ack)
        else $error("link ack too long");
    ack_with_req_a: assert property (ack |-> req)
        else $error("link ack without request");
    req_hold_a: assert property (
        req && !ack |=> req && $stable({we, addr, wdata}))
        else $error("link request changed early");
    req_release_a: assert property (ack |=> !req)
        else $error("link request not released");
    dis_readback_a: assert property (
        ack && !we && addr == DISCHARGE_OFS |-> rdata == {7'h00, dis_q})
        else $error("discharge readback wrong");
    unmapped_read_a: assert property (ack && !we && !rd_map |-> rdata == 8'h00)
        else $error("unmapped read not zero");
    reset_quiet_a: assert property (
        $fell(rst_i) |-> !ack && !pa_boost_fault_flag)
        else $error("link busy after reset");
    cover property (ack && we);
    cover property (ack && !we && addr == DISCHARGE_OFS);
    cover property ($rose(pa_boost_fault_flag));
    cover property ($rose(standby_exit_pin));
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
    import pa_boost_pkg::*;
;
    logic clk_i, rst_i, ce_i, cyc, stb, wwe, wack, irq_o, uv, oc, sc, ov;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, wdo, rdat;
    logic reg_en, uv_en, blk, iso, dis_en, v5, ss;
    int fail_count, samples_checked;
    pa_link_if link();
    pa_boost_supervisor #(.SOFTSTART_CYCLES(20)) u_pa_boost_supervisor (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .link(link),
        .uv_low_i(uv), .oc_i(oc), .sc_i(sc), .ov_i(ov),
        .pa_boost_regulator_en_o(reg_en), .uv_comp_en_o(uv_en),
        .switch_block_o(blk), .isolation_switch_en_o(iso),
        .discharge_en_o(dis_en), .vsel_5v0_o(v5), .soft_start_o(ss));
    pa_boost_host_ctrl u_pa_boost_host_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_sel_i(sel), .wb_dat_o(wdo), .wb_ack_o(wack), .irq_o(irq_o),
        .link(link));
    pa_link_properties u_pa_link_properties (
        .clk_i(clk_i), .rst_i(rst_i), .req(link.req), .we(link.we),
        .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
        .ack(link.ack), .pa_boost_fault_flag(link.pa_boost_fault_flag),
        .standby_exit_pin(link.standby_exit_pin));
    // clock source
    initial begin
        clk_i = 0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // one classic wishbone cycle, read data kept in rdat
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        wwe <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (wack !== 1'b1);
        rdat = wdo;
        cyc <= 0;
        stb <= 0;
    endtask
    // device register access through the command register
    task automatic dev(input logic w, input logic [8:0] a,
                       input logic [7:0] d);
        wb(1, HC_CMD_OFS, {1'b1, 6'h00, w, d, 7'h00, a});
        do wb(0, HC_STAT_OFS, 0); while (rdat[0] !== 1'b0);
    endtask
    // comparator levels, then time for filter and flag
    task automatic pins(input logic [3:0] p);
        @(posedge clk_i);
        {ov, sc, oc, uv} <= p;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic t_reset();
        dev(0, STATE_VOLTAGE_OFS, 0);
        chk("state reset", STATE_VOLTAGE_RST, rdat[15:8]);
        dev(0, DISCHARGE_OFS, 0);
        chk("discharge reset", DISCHARGE_RST, rdat[15:8]);
        dev(0, 9'h100, 0);
        chk("unmapped device", 0, rdat[15:8]);
        wb(0, 8'h20, 0);
        chk("unmapped host", 0, rdat);
        chk("regulator off", 0, reg_en);
        $display("test reset done");
    endtask
    task automatic t_uv();
        wb(1, HC_IRQ_MASK_OFS, 32'h2);
        pins(4'h1);
        dev(1, STATE_VOLTAGE_OFS, 8'h27);
        repeat (8) @(posedge clk_i);
        chk("on", 1, reg_en);
        chk("uv comparator", 1, uv_en);
        chk("select 4v2", 0, v5);
        chk("fault ramp", 1, link.pa_boost_fault_flag);
        chk("irq set", 1, irq_o);
        pins(4'h0);
        chk("fault settled", 0, link.pa_boost_fault_flag);
        wb(1, HC_IRQ_STAT_OFS, 32'h7);
        wb(1, HC_IRQ_MASK_OFS, 32'h0);
        pins(4'h1);
        chk("fault low out", 1, link.pa_boost_fault_flag);
        chk("irq masked", 0, irq_o);
        wb(0, HC_IRQ_STAT_OFS, 0);
        chk("irq status", 1, rdat[IRQ_FAULT_SET]);
        pins(4'h0);
        chk("uv recovered", 0, link.pa_boost_fault_flag);
        $display("test under-voltage done");
    endtask
    task automatic t_oc();
        pins(4'h2);
        chk("switch blocked", 1, blk);
        chk("fault oc", 1, link.pa_boost_fault_flag);
        pins(4'h3);
        pins(4'h1);
        chk("fault uv left", 1, link.pa_boost_fault_flag);
        chk("switch resumed", 0, blk);
        pins(4'h0);
        chk("fault oc clear", 0, link.pa_boost_fault_flag);
        $display("test over-current done");
    endtask
    task automatic t_sc();
        dev(1, STATE_VOLTAGE_OFS, 8'h24);
        pins(4'h4);
        dev(1, STATE_VOLTAGE_OFS, 8'hA7);
        chk("soft start", 1, ss);
        chk("sc blanked", 1, reg_en);
        chk("select 5v0", 1, v5);
        repeat (40) @(posedge clk_i);
        chk("sc off", 0, reg_en);
        chk("isolation off", 0, iso);
        pins(4'h0);
        chk("sc latched", 1, link.pa_boost_fault_flag);
        chk("no restart", 0, reg_en);
        dev(1, STATE_VOLTAGE_OFS, 8'hA7);
        repeat (8) @(posedge clk_i);
        chk("sc cleared", 0, link.pa_boost_fault_flag);
        $display("test short done");
    endtask
    task automatic t_ov();
        pins(4'h8);
        pins(4'h0);
        chk("ov off", 0, reg_en);
        chk("ov latched", 1, link.pa_boost_fault_flag);
        dev(1, STATE_VOLTAGE_OFS, 8'h3C);
        wb(1, HC_STBY_OFS, 1);
        repeat (8) @(posedge clk_i);
        chk("standby on", 1, reg_en);
        chk("ov cleared", 0, link.pa_boost_fault_flag);
        dev(0, STATE_VOLTAGE_OFS, 0);
        chk("copied", 8'h3F, rdat[15:8]);
        wb(1, HC_STBY_OFS, 0);
        dev(1, STATE_VOLTAGE_OFS, 8'h14);
        wb(1, HC_STBY_OFS, 1);
        dev(0, STATE_VOLTAGE_OFS, 0);
        chk("not copied", 8'h14, rdat[15:8]);
        $display("test over-voltage done");
    endtask
    // clock enable low freezes filter and flag
    task automatic t_ce();
        dev(1, STATE_VOLTAGE_OFS, 8'h27);
        @(posedge clk_i);
        ce_i <= 1'b0;
        pins(4'h1);
        chk("frozen fault", 0, link.pa_boost_fault_flag);
        chk("frozen on", 1, reg_en);
        @(posedge clk_i);
        ce_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk("thawed fault", 1, link.pa_boost_fault_flag);
        pins(4'h0);
        dev(1, STATE_VOLTAGE_OFS, 8'h24);
        chk("ce off", 0, reg_en);
        $display("test clock enable done");
    endtask
    task automatic t_dis();
        dev(1, DISCHARGE_OFS, 8'h00);
        chk("discharge on", 1, dis_en);
        dev(1, DISCHARGE_OFS, 8'hFF);
        dev(0, DISCHARGE_OFS, 0);
        chk("discharge bits", 8'h01, rdat[15:8]);
        chk("discharge off", 0, dis_en);
        $display("test discharge done");
    endtask
    // main sequence
    initial begin
        rst_i = 1;
        ce_i = 1;
        sel = 4'hF;
        {cyc, stb, wwe, adr, wdat, ov, sc, oc, uv} = '0;
        fail_count = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        t_reset();
        t_uv();
        t_oc();
        t_sc();
        t_ov();
        t_ce();
        t_dis();
        end_sim();
    end
    // watchdog
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        end_sim();
    end
endmodule
